// File: rtl/psfg_call_addr.sv
`timescale 1ns/100ps
`include "psfg_map.svh"
// near-call target formation with stack pointer as base
module psfg_call_addr
(
  // clock and reset
  input  wire logic                    clock,
  input  wire logic                    rst,
  // call request
  input  wire logic                    call_valid,
  input  wire logic                    call_sp_base,
  input  wire logic [`PSFG_XLEN-1:0]   call_base_reg,
  input  wire logic [`PSFG_XLEN-1:0]   call_disp,
  input  wire logic [`PSFG_XLEN-1:0]   stack_pointer_register,
  // target result
  output logic                         target_valid,
  output logic [`PSFG_XLEN-1:0]        target_addr
);
  // registered result
  logic                  tv_r;
  logic                  tv_nxt;
  logic [`PSFG_XLEN-1:0] ta_r;
  logic [`PSFG_XLEN-1:0] ta_nxt;

  // stack_pointer_register is the value before the call pushes anything
  always_comb
  begin
    tv_nxt = call_valid;
    ta_nxt = ta_r;
    if (call_valid)
    begin
      if (call_sp_base)
      begin
        ta_nxt = stack_pointer_register + call_disp; // RQ13
      end
      else
      begin
        ta_nxt = call_base_reg + call_disp;
      end
    end
  end

  // register the result
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      tv_r <= 1'b0;
      ta_r <= 32'h00000000;
    end
    else
    begin
      tv_r <= tv_nxt;
      ta_r <= ta_nxt;
    end
  end

  assign target_valid = tv_r;
  assign target_addr  = ta_r;

  // the target uses the pre-call stack pointer
  a_call_sp_base : assert property (@(posedge clock) disable iff (rst)
    (call_valid && call_sp_base) |=>
    target_addr == $past(stack_pointer_register) + $past(call_disp)) // RQ13
    else $error("sp-based call used wrong base");
endmodule

// File: rtl/psfg_gate.sv
// Function
// (RQ1) faulting store never changes memory state
// (RQ2) emulation flag raises invalid opcode, no write
// (RQ3) nonzero stack top runs clearing assist first
// (RQ4) pending unmasked fp exception signalled before write
// (RQ5) task switched flag raises device unavailable
// (RQ6) restart after assist and device unavailable
// (RQ7) reset clears fp data operand pointer
// (RQ8) software masks self-test bit six
// (RQ9) passing self-test reports all-zero result
// (RQ10) agents judge memory type by transaction
// (RQ11) snoop miss skips parity, no machine check
// (RQ12) doubleword copy keeps upper bits zero
// (RQ13) sp-based near call uses pre-call sp
// (RQ14) hold commit until all checks resolve
`timescale 1ns/100ps
`include "psfg_map.svh"
module psfg_gate
#(
  parameter int PW = `PSFG_PLEN
)
(
  // clock and reset
  input  wire logic                       clock,
  input  wire logic                       rst,
  // architectural state from the pipeline
  input  wire logic                       emulation_flag,
  input  wire logic                       task_switched_flag,
  input  wire logic [`PSFG_TOS_W-1:0]     fp_stack_top,
  input  wire logic                       fp_exc_pending,
  input  wire logic                       checks_resolved,
  // packed store request from the pipeline
  input  wire logic                       st_req,
  input  wire logic                       st_quad,
  input  wire logic [`PSFG_XLEN-1:0]      st_addr,
  input  wire logic [PW-1:0]              st_data,
  // packed store outcome to the pipeline
  output logic                            st_busy,
  output logic                            st_done,
  output psfg_pkg::psfg_res_t             st_result,
  output logic                            st_restart,
  output logic                            tos_assist_req,
  input  wire logic                       tos_assist_done,
  // memory write port
  output logic                            mem_wr,
  output logic [`PSFG_XLEN-1:0]           mem_addr,
  output logic [PW-1:0]                   mem_data,
  output logic [PW/8-1:0]                 mem_be,
  // packed doubleword move from a general register
  input  wire logic                       packed_move_doubleword_valid,
  input  wire logic [`PSFG_XLEN-1:0]      packed_move_doubleword_src,
  output logic [PW-1:0]                   packed_move_doubleword_dst,
  // fp data operand pointer
  input  wire logic                       fdp_load,
  input  wire logic [`PSFG_XLEN-1:0]      fdp_value,
  output logic [`PSFG_XLEN-1:0]           fp_data_ptr,
  // self-test
  input  wire logic                       builtin_self_test_run,
  input  wire logic                       builtin_self_test_fail,
  output logic [`PSFG_XLEN-1:0]           accumulator_register,
  // snoop parity
  input  wire logic                       snoop_valid,
  input  wire logic                       snoop_hit,
  input  wire logic [PW-1:0]              snoop_data,
  input  wire logic                       snoop_parity,
  output logic                            machine_check_fault,
  // near-call addressing
  input  wire logic                       call_valid,
  input  wire logic                       call_sp_base,
  input  wire logic [`PSFG_XLEN-1:0]      call_base_reg,
  input  wire logic [`PSFG_XLEN-1:0]      call_disp,
  input  wire logic [`PSFG_XLEN-1:0]      stack_pointer_register,
  output logic                            target_valid,
  output logic [`PSFG_XLEN-1:0]           target_addr
);
  // all state of the gate
  typedef struct packed
  {
    psfg_pkg::psfg_state_t  st;       // gate state
    logic                   quad;     // held store width
    logic [`PSFG_XLEN-1:0]  addr;     // held store address
    logic [PW-1:0]          data;     // held store data
    logic                   wr;       // memory write strobe
    logic [PW/8-1:0]        be;       // byte enables of the write
    logic                   done;     // outcome pulse
    psfg_pkg::psfg_res_t    res;      // outcome code
    logic                   restart;  // restart request with outcome
    logic [PW-1:0]          packed_move_doubleword;     // packed register result
    logic [`PSFG_XLEN-1:0]  fdp;      // fp data operand pointer
    logic [`PSFG_XLEN-1:0]  builtin_self_test;     // self-test result
  } psfg_state_s_t;

  psfg_state_s_t s_r;
  psfg_state_s_t s_nxt;

  // any blocking condition for a packed store
  function automatic logic psfg_blocked(input logic em, input logic ts,
                                        input logic [`PSFG_TOS_W-1:0] tos,
                                        input logic fpx);
    psfg_blocked = em || ts || (tos != `PSFG_TOS_CLEAR) || fpx;
  endfunction

  // next-state logic
  always_comb
  begin
    s_nxt         = s_r;
    s_nxt.wr      = 1'b0;
    s_nxt.done    = 1'b0;
    s_nxt.restart = 1'b0;
    s_nxt.res     = psfg_pkg::PSFG_RES_NONE;
    case (s_r.st)
      // take a new store
      psfg_pkg::PSFG_IDLE:
      begin
        if (st_req)
        begin
          s_nxt.st   = psfg_pkg::PSFG_CHECK;
          s_nxt.quad = st_quad;
          s_nxt.addr = st_addr;
          s_nxt.data = st_data;
        end
      end
      // wait for checks, then fault, assist or commit
      psfg_pkg::PSFG_CHECK:
      begin
        if (checks_resolved) // RQ14
        begin
          s_nxt.done = 1'b1;
          s_nxt.st   = psfg_pkg::PSFG_IDLE;
          if (emulation_flag)
          begin
            s_nxt.res = psfg_pkg::PSFG_RES_INVALID_OP; // RQ2
          end
          else if (task_switched_flag)
          begin
            s_nxt.res     = psfg_pkg::PSFG_RES_DEV_UNAVAIL; // RQ5
            s_nxt.restart = 1'b1; // RQ6
          end
          else if (fp_stack_top != `PSFG_TOS_CLEAR)
          begin
            s_nxt.done = 1'b0;
            s_nxt.st   = psfg_pkg::PSFG_ASSIST; // RQ3
          end
          else if (fp_exc_pending)
          begin
            s_nxt.res = psfg_pkg::PSFG_RES_FP_EXC; // RQ4
          end
          else
          begin
            // only an unblocked store reaches memory
            s_nxt.wr  = 1'b1; // RQ1
            s_nxt.be  = s_r.quad ? 8'hFF : 8'h0F;
            s_nxt.res = psfg_pkg::PSFG_RES_COMMIT;
          end
        end
      end
      // stack-top assist runs, then the store is restarted
      psfg_pkg::PSFG_ASSIST:
      begin
        if (tos_assist_done)
        begin
          s_nxt.done    = 1'b1;
          s_nxt.res     = psfg_pkg::PSFG_RES_TOS_ASSIST;
          s_nxt.restart = 1'b1; // RQ6
          s_nxt.st      = psfg_pkg::PSFG_IDLE;
        end
      end
      default:
      begin
        s_nxt.st = psfg_pkg::PSFG_IDLE;
      end
    endcase
    // doubleword copy zero-extends, the upper half never takes the sign
    if (packed_move_doubleword_valid)
    begin
      s_nxt.packed_move_doubleword = {{(PW-`PSFG_XLEN){1'b0}}, packed_move_doubleword_src}; // RQ12
    end
    // fp data operand pointer load
    if (fdp_load)
    begin
      s_nxt.fdp = fdp_value;
    end
    // self-test: pass gives all zeros, bit 6 is not forced
    if (builtin_self_test_run)
    begin
      s_nxt.builtin_self_test = builtin_self_test_fail ? 32'h00000001 : `PSFG_BUILTIN_SELF_TEST_PASS; // RQ9
    end
  end

  // state register
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      s_r      <= '0;
      s_r.st   <= psfg_pkg::PSFG_IDLE;
      s_r.fdp  <= `PSFG_FDP_RST; // RQ7
      s_r.builtin_self_test <= `PSFG_BUILTIN_SELF_TEST_PASS;
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  // outputs
  assign st_busy              = (s_r.st != psfg_pkg::PSFG_IDLE);
  assign st_done              = s_r.done;
  assign st_result            = s_r.res;
  assign st_restart           = s_r.restart;
  assign tos_assist_req       = (s_r.st == psfg_pkg::PSFG_ASSIST);
  assign mem_wr               = s_r.wr;
  assign mem_addr             = s_r.addr;
  assign mem_data             = s_r.data;
  assign mem_be               = s_r.be;
  assign packed_move_doubleword_dst             = s_r.packed_move_doubleword;
  assign fp_data_ptr          = s_r.fdp;
  assign accumulator_register = s_r.builtin_self_test;

  // snoop parity checker
  psfg_snoop_parity #(.DW(PW)) u_snoop
  (
    .clock               (clock),
    .rst                 (rst),
    .snoop_valid         (snoop_valid),
    .snoop_hit           (snoop_hit),
    .snoop_data          (snoop_data),
    .snoop_parity        (snoop_parity),
    .machine_check_fault (machine_check_fault)
  );

  // near-call target former
  psfg_call_addr u_call
  (
    .clock                  (clock),
    .rst                    (rst),
    .call_valid             (call_valid),
    .call_sp_base           (call_sp_base),
    .call_base_reg          (call_base_reg),
    .call_disp              (call_disp),
    .stack_pointer_register (stack_pointer_register),
    .target_valid           (target_valid),
    .target_addr            (target_addr)
  );

  // no write while any blocking condition holds at commit time
  a_no_faulted_write : assert property (@(posedge clock) disable iff (rst)
    (s_r.st == psfg_pkg::PSFG_CHECK && checks_resolved &&
     psfg_blocked(emulation_flag, task_switched_flag, fp_stack_top, fp_exc_pending))
    |=> !mem_wr) // RQ1
    else $error("blocked packed store reached memory");
  a_emu_invalid_op : assert property (@(posedge clock) disable iff (rst)
    (s_r.st == psfg_pkg::PSFG_CHECK && checks_resolved && emulation_flag)
    |=> st_done && st_result == psfg_pkg::PSFG_RES_INVALID_OP && !st_restart) // RQ2
    else $error("emulation flag did not raise invalid opcode");
  a_tos_assist : assert property (@(posedge clock) disable iff (rst)
    (s_r.st == psfg_pkg::PSFG_CHECK && checks_resolved && !emulation_flag &&
     !task_switched_flag && fp_stack_top != `PSFG_TOS_CLEAR)
    |=> tos_assist_req && !mem_wr) // RQ3
    else $error("stack-top assist not entered");
  a_fp_exc_first : assert property (@(posedge clock) disable iff (rst)
    (s_r.st == psfg_pkg::PSFG_CHECK && checks_resolved && !emulation_flag &&
     !task_switched_flag && fp_stack_top == `PSFG_TOS_CLEAR && fp_exc_pending)
    |=> st_result == psfg_pkg::PSFG_RES_FP_EXC) // RQ4
    else $error("pending fp exception not signalled");
  a_ts_dev_unavail : assert property (@(posedge clock) disable iff (rst)
    (s_r.st == psfg_pkg::PSFG_CHECK && checks_resolved && !emulation_flag &&
     task_switched_flag)
    |=> st_result == psfg_pkg::PSFG_RES_DEV_UNAVAIL && st_restart) // RQ5
    else $error("task switched flag did not fault");
  a_assist_restart : assert property (@(posedge clock) disable iff (rst)
    (tos_assist_req && tos_assist_done) |=> st_restart && st_done) // RQ6
    else $error("no restart after assist");
  a_fdp_reset : assert property (@(posedge clock)
    $past(rst) |-> fp_data_ptr == `PSFG_FDP_RST) // RQ7
    else $error("fp data pointer not cleared by reset");
  a_builtin_self_test_pass_zero : assert property (@(posedge clock) disable iff (rst)
    (builtin_self_test_run && !builtin_self_test_fail)
    |=> accumulator_register == `PSFG_BUILTIN_SELF_TEST_PASS) // RQ9
    else $error("passing self-test not zero");
  a_packed_move_doubleword_upper_zero : assert property (@(posedge clock) disable iff (rst)
    packed_move_doubleword_valid |=> packed_move_doubleword_dst[`PSFG_XLEN-1:`PSFG_LOW_HALF_W] == 16'h0000 ||
                   $past(packed_move_doubleword_src[`PSFG_XLEN-1:`PSFG_LOW_HALF_W]) != 16'h0000) // RQ12
    else $error("doubleword copy replicated the sign");
  a_hold_commit : assert property (@(posedge clock) disable iff (rst)
    (s_r.st == psfg_pkg::PSFG_CHECK && !checks_resolved) |=> !mem_wr && st_busy) // RQ14
    else $error("commit before checks resolved");
endmodule

// File: rtl/psfg_map.svh
`ifndef PSFG_MAP_SVH
`define PSFG_MAP_SVH
// pipeline register widths
`define PSFG_XLEN           32
`define PSFG_PLEN           64
// fp stack-top field width and the value that lets a packed store commit
`define PSFG_TOS_W          3
`define PSFG_TOS_CLEAR      3'h0
// reset value of the fp data operand pointer
`define PSFG_FDP_RST        32'h00000000
// self-test result: passing code and the bit software masks, which the gate never sets
`define PSFG_BUILTIN_SELF_TEST_PASS      32'h00000000
`define PSFG_BUILTIN_SELF_TEST_STUCK_BIT 6
// sign-extension boundary for the packed doubleword copy
`define PSFG_LOW_HALF_W     16
`endif

// File: rtl/psfg_pkg.sv
package psfg_pkg;
  // outcome of the fault gate for one packed store
  typedef enum logic [2:0]
  {
    PSFG_RES_NONE,
    PSFG_RES_COMMIT,
    PSFG_RES_INVALID_OP,
    PSFG_RES_DEV_UNAVAIL,
    PSFG_RES_FP_EXC,
    PSFG_RES_TOS_ASSIST
  } psfg_res_t;
  // gate state machine states
  typedef enum logic [1:0]
  {
    PSFG_IDLE,
    PSFG_CHECK,
    PSFG_ASSIST
  } psfg_state_t;
endpackage

// File: rtl/psfg_snoop_parity.sv
`timescale 1ns/100ps
`include "psfg_map.svh"
// parity check on snoop data, only where lines are driven by a hit
module psfg_snoop_parity
#(
  parameter int DW = 64
)
(
  // clock and reset
  input  wire logic          clock,
  input  wire logic          rst,
  // snoop side
  input  wire logic          snoop_valid,
  input  wire logic          snoop_hit,
  input  wire logic [DW-1:0] snoop_data,
  input  wire logic          snoop_parity,
  // fault output
  output logic               machine_check_fault
);
  // registered fault flag
  logic mcf_r;
  logic mcf_nxt;

  // a miss leaves data lines undriven, so parity is looked at only on a hit
  always_comb
  begin
    mcf_nxt = 1'b0;
    if (snoop_valid && snoop_hit)
    begin
      mcf_nxt = (^snoop_data) != snoop_parity; // RQ11
    end
  end

  // register the fault
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      mcf_r <= 1'b0;
    end
    else
    begin
      mcf_r <= mcf_nxt;
    end
  end

  assign machine_check_fault = mcf_r;

  // a snoop miss never leads to a fault
  a_snoop_miss_quiet : assert property (@(posedge clock) disable iff (rst)
    (snoop_valid && !snoop_hit) |=> !machine_check_fault) // RQ11
    else $error("snoop miss raised a machine check");
endmodule

// File: verification/psfg_gate_tb_top.sv
`timescale 1ns/100ps
// self-checking bench for the packed store fault gate
module psfg_gate_tb_top;
  // clock, reset and bookkeeping
  logic        clock, rst;
  int          fails, cmp_count, exp_wr, i;
  // gate inputs
  logic        emulation_flag, task_switched_flag, fp_exc_pending, checks_resolved;
  logic [2:0]  fp_stack_top;
  logic        st_req, st_quad, packed_move_doubleword_valid, fdp_load;
  logic [31:0] st_addr, packed_move_doubleword_src, fdp_value;
  logic [63:0] st_data, snoop_data;
  logic        builtin_self_test_run, builtin_self_test_fail;
  logic        snoop_valid, snoop_hit, snoop_parity, call_valid, call_sp_base;
  logic [31:0] call_base_reg, call_disp, stack_pointer_register;
  logic [3:0]  assist_wait;
  // gate and model outputs
  logic        st_busy, st_done, st_restart, tos_assist_req, tos_assist_done, mem_wr;
  logic        machine_check_fault, target_valid;
  logic [31:0] mem_addr, fp_data_ptr, accumulator_register, target_addr;
  logic [63:0] mem_data, packed_move_doubleword_dst;
  logic [7:0]  mem_be;
  int          wr_count;
  psfg_pkg::psfg_res_t st_result;
  // fault table: flags {emulation, task switched, stack top, fp exception}
  logic [3:0]          flt [7] = '{4'h8, 4'h4, 4'h2, 4'h1, 4'hF, 4'h7, 4'h3};
  psfg_pkg::psfg_res_t res [7] = '{psfg_pkg::PSFG_RES_INVALID_OP,
    psfg_pkg::PSFG_RES_DEV_UNAVAIL, psfg_pkg::PSFG_RES_TOS_ASSIST, psfg_pkg::PSFG_RES_FP_EXC,
    psfg_pkg::PSFG_RES_INVALID_OP, psfg_pkg::PSFG_RES_DEV_UNAVAIL,
    psfg_pkg::PSFG_RES_TOS_ASSIST};
  logic [6:0]          rs_tab = 7'h66;  // entries that must be restarted

  // design under test
  psfg_gate #(.PW(64)) i_dut
  (
    .clock, .rst, .emulation_flag, .task_switched_flag, .fp_stack_top, .fp_exc_pending,
    .checks_resolved, .st_req, .st_quad, .st_addr, .st_data, .st_busy, .st_done,
    .st_result, .st_restart, .tos_assist_req, .tos_assist_done, .mem_wr, .mem_addr,
    .mem_data, .mem_be, .packed_move_doubleword_valid, .packed_move_doubleword_src, .packed_move_doubleword_dst, .fdp_load, .fdp_value,
    .fp_data_ptr, .builtin_self_test_run, .builtin_self_test_fail, .accumulator_register,
    .snoop_valid, .snoop_hit, .snoop_data, .snoop_parity, .machine_check_fault,
    .call_valid, .call_sp_base, .call_base_reg, .call_disp, .stack_pointer_register,
    .target_valid, .target_addr
  );
  // pipeline and memory model
  psfg_pipe_model i_pipe
  (
    .clock, .rst, .assist_wait, .tos_assist_req, .tos_assist_done, .mem_wr, .wr_count
  );

  // compare one value, report and count a mismatch
  task automatic check(input logic [63:0] seen, input logic [63:0] exp, input string what);
    cmp_count++;
    if (seen !== exp)
    begin
      fails++;
      $display("wrong value at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  // print counts and verdict, then stop
  task automatic complete_run;
    $display("comparisons %0d, mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // drive the four fault conditions
  task automatic set_flags(input logic [3:0] f);
    emulation_flag     <= f[3];
    task_switched_flag <= f[2];
    fp_stack_top       <= f[1] ? 3'h5 : 3'h0;
    fp_exc_pending     <= f[0];
  endtask

  // one packed store; with hold, conditions stay unresolved and a second request is refused
  task automatic store(input logic q, input logic [3:0] f, input int hold,
                       input psfg_pkg::psfg_res_t er, input logic ers);
    int          n;
    logic [31:0] a;
    logic [63:0] d;
    logic        sa;
    a = 32'h0000_1000 + cmp_count;
    d = {a, ~a};
    sa = 1'b0;
    @(posedge clock);
    set_flags(hold > 0 ? 4'h0 : f);
    checks_resolved <= (hold == 0);
    st_req          <= 1'b1;
    st_quad         <= q;
    st_addr         <= a;
    st_data         <= d;
    @(posedge clock);
    st_req  <= 1'b0;
    st_addr <= 32'hFFFF_FFF0;
    for (n = 0; n < hold; n++)
    begin
      @(negedge clock);
      check(st_done | mem_wr, 1'b0, "finish before resolved");
      check(st_busy, 1'b1, "busy while checking");
      @(posedge clock);
      st_req <= (n == 0);
      if (n == hold - 1)
      begin
        set_flags(f);
        checks_resolved <= 1'b1;
      end
    end
    n = 0;
    do
    begin
      @(negedge clock);
      n++;
      sa = sa | tos_assist_req;
    end
    while (st_done !== 1'b1 && n < 40);
    check(st_done, 1'b1, "store done");
    check(st_result, er, "store result");
    check(st_restart, ers, "restart");
    check(sa, er == psfg_pkg::PSFG_RES_TOS_ASSIST, "assist requested");
    check(mem_wr, er == psfg_pkg::PSFG_RES_COMMIT, "memory write");
    if (er == psfg_pkg::PSFG_RES_COMMIT)
    begin
      exp_wr++;
      check({mem_addr, mem_be}, {a, q ? 8'hFF : 8'h0F}, "write address");
      check(mem_data, d, "write data");
    end
  endtask

  // clock
  initial
  begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  // watchdog: the tests need well under a thousand cycles
  initial
  begin
    repeat (4000) @(posedge clock);
    fails++;
    complete_run;
  end

  // main sequence
  initial
  begin
    {rst, emulation_flag, task_switched_flag, fp_exc_pending, checks_resolved} = 5'h10;
    {st_req, st_quad, packed_move_doubleword_valid, fdp_load, builtin_self_test_run} = 5'h0;
    {builtin_self_test_fail, snoop_valid, snoop_hit, snoop_parity} = 4'h0;
    {call_valid, call_sp_base, fp_stack_top, assist_wait} = 9'h0;
    {st_addr, packed_move_doubleword_src, fdp_value, call_base_reg, call_disp} = 160'h0;
    {st_data, snoop_data, stack_pointer_register} = 160'h0;
    {fails, cmp_count, exp_wr} = 96'h0;
    repeat (3) @(posedge clock);
    rst <= 1'b0;
    @(negedge clock);
    check({fp_data_ptr, accumulator_register}, 64'h0, "reset state");
    check({st_busy, st_done, mem_wr}, 3'h0, "reset outputs");
    // pointer loaded, then a second reset must clear it again
    @(posedge clock);
    fdp_load  <= 1'b1;
    fdp_value <= 32'hA5A5_0040;
    @(posedge clock);
    fdp_load <= 1'b0;
    rst      <= 1'b1;
    @(negedge clock);
    check(fp_data_ptr, 32'hA5A5_0040, "pointer load");
    repeat (3) @(posedge clock);
    rst <= 1'b0;
    @(negedge clock);
    check(fp_data_ptr, 32'h0, "pointer after reset");
    $display("test reset done");
    // clean store held unresolved, then each single fault and three fault mixes, reissued after each restart
    store(1'b1, 4'h0, 3, psfg_pkg::PSFG_RES_COMMIT, 1'b0);
    for (i = 0; i < 7; i++)
    begin
      assist_wait = i[3:0];
      store(i[0], flt[i], (i == 6) ? 3 : 0, res[i], rs_tab[i]);
      if (rs_tab[i])
        store(i[0], 4'h0, 0, psfg_pkg::PSFG_RES_COMMIT, 1'b0);
    end
    repeat (2) @(posedge clock);
    check(wr_count, exp_wr, "memory write count");
    $display("test stores done");
    // doubleword copy of a negative low half keeps bits 16-31 clear
    @(posedge clock);
    packed_move_doubleword_valid <= 1'b1;
    packed_move_doubleword_src   <= 32'h0000_8005;
    @(posedge clock);
    packed_move_doubleword_valid <= 1'b0;
    @(negedge clock);
    check(packed_move_doubleword_dst, 64'h0000_0000_0000_8005, "doubleword copy");
    // self-test pass then fail, stuck bit masked as software does
    for (i = 0; i < 2; i++)
    begin
      @(posedge clock);
      builtin_self_test_run  <= 1'b1;
      builtin_self_test_fail <= i[0];
      @(posedge clock);
      builtin_self_test_run <= 1'b0;
      @(negedge clock);
      check((accumulator_register & 32'hFFFF_FFBF) != 0, i[0], "self-test");
    end
    // snoop: miss with bad parity, hit with bad parity, hit with good parity
    for (i = 0; i < 3; i++)
    begin
      @(posedge clock);
      snoop_valid  <= 1'b1;
      snoop_hit    <= (i > 0);
      snoop_data   <= 64'h0000_0000_0000_0001;
      snoop_parity <= (i == 2);
      @(posedge clock);
      snoop_valid <= 1'b0;
      @(negedge clock);
      check(machine_check_fault, i == 1, "machine check");
    end
    // near call: stack-pointer base uses the value from before the push
    for (i = 0; i < 2; i++)
    begin
      @(posedge clock);
      call_valid             <= 1'b1;
      call_sp_base           <= ~i[0];
      call_base_reg          <= 32'h0000_7FFC;
      call_disp              <= 32'h0000_0010;
      stack_pointer_register <= 32'h0000_8000;
      @(posedge clock);
      call_valid <= 1'b0;
      @(negedge clock);
      check({target_valid, target_addr}, {1'b1, i[0] ? 32'h0000_800C : 32'h0000_8010},
            "call target");
    end
    $display("test side paths done");
    complete_run;
  end
endmodule

// File: verification/psfg_pipe_model.sv
`timescale 1ns/100ps
// far side of the gate: pipeline answering the stack-top assist, memory counting writes
module psfg_pipe_model
(
  // clock and reset
  input  wire logic       clock,
  input  wire logic       rst,
  // assist handshake, answered after assist_wait cycles
  input  wire logic [3:0] assist_wait,
  input  wire logic       tos_assist_req,
  output logic            tos_assist_done,
  // memory write strobe
  input  wire logic       mem_wr,
  output int              wr_count
);
  logic [3:0] wait_r;  // cycles the assist has been requested
  logic       sent_r;  // this request has had its answer
  // one done pulse per request; a held request is not answered twice
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      wait_r          <= 4'h0;
      sent_r          <= 1'b0;
      tos_assist_done <= 1'b0;
    end
    else
    begin
      tos_assist_done <= 1'b0;
      if (!tos_assist_req)
      begin
        wait_r <= 4'h0;
        sent_r <= 1'b0;
      end
      else if (!sent_r && wait_r == assist_wait)
      begin
        tos_assist_done <= 1'b1;
        sent_r          <= 1'b1;
      end
      else if (!sent_r)
        wait_r <= wait_r + 4'h1;
    end
  end
  // memory side: every write strobe is one memory update
  // the gate only issues memory transactions, so no memory-type field is judged here
  always_ff @(posedge clock)
  begin
    if (rst)
      wr_count <= 0;
    else if (mem_wr)
      wr_count <= wr_count + 1;
  end
endmodule
